/* File: hw/balf_pkg.sv */
package balf_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W = 10;
  localparam int unsigned NREG = 16;
  localparam int unsigned RIDX_W = 4;
  localparam int unsigned ADDR_W = 8;

  // Byte offsets on the register bus
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_SAVED_PC = 8'h0c;
  localparam logic [7:0] OFS_REGFILE = 8'h40;

  // Command word field positions
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_IMM_SEL = 3;
  localparam int unsigned CMD_X_LSB = 4;
  localparam int unsigned CMD_Y_LSB = 8;
  localparam int unsigned CMD_K_LSB = 16;

  // Status word bit positions
  localparam int unsigned ST_ZERO = 0;
  localparam int unsigned ST_CARRY = 1;
  localparam int unsigned ST_INT_EN = 2;

  localparam logic [PC_W-1:0] RESET_VECTOR = 10'h000;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 10'h3ff;
  localparam logic [DATA_W-1:0] BYTE_MAX = 8'hff;

  typedef enum logic [2:0] {
    BALF_OP_ADD = 3'b000,
    BALF_OP_ADDC = 3'b001,
    BALF_OP_AND = 3'b010,
    BALF_OP_EINT = 3'b011,
    BALF_OP_DINT = 3'b100,
    BALF_OP_RET_EN = 3'b101,
    BALF_OP_RET_DIS = 3'b110,
    BALF_OP_NOP = 3'b111
  } balf_op_t;
endpackage : balf_pkg

/* File: hw/balf_core.sv */
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Add writes low byte of sum back
// RULE2 - Add sets carry when sum exceeds 255
// RULE3 - Add sets zero when sum is 0/256
// RULE4 - Plain add ignores previous carry
// RULE5 - First operand destination; second register or immediate
// RULE6 - Add-with-carry adds one when carry set
// RULE7 - Add-with-carry carry when total exceeds 255
// RULE8 - Add-with-carry zero when total is 0/256
// RULE9 - AND bitwise, stores result, zero if zero
// RULE10 - AND always clears carry
// RULE11 - Old values read, all updates commit together
// RULE12 - Reset starts fetch at address zero
// RULE13 - Interrupt branches to vector 3ff
// RULE14 - Interrupt recognition clears interrupt enable
// RULE15 - Return variants re-enable or keep disabled
// RULE16 - Enable instruction sets flag; gates interrupt
// RULE17 - ALU operations advance program counter by one
// RULE18 - Carry and zero persist between operations
module balf_core
  import balf_pkg::*;
(
  input wire logic sys_clk, // Core clock, 10 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic irq, // Interrupt request level
  input wire logic [balf_pkg::ADDR_W-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Write byte lanes
  output logic [31:0] avs_readdata, // Read data, registered
  output logic avs_waitrequest // Stall until answer ready
);
  import balf_pkg::*;

  typedef struct packed {
    logic [NREG-1:0][DATA_W-1:0] regs;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] saved_pc;
    logic carry;
    logic zero;
    logic saved_carry;
    logic saved_zero;
    logic interrupt_enable_flag;
    logic ack;
    logic [31:0] rdata;
  } balf_state_t;

  balf_state_t st_q;
  balf_state_t st_d;

  function automatic logic [DATA_W:0] add9(input logic [DATA_W-1:0] a,
                                            input logic [DATA_W-1:0] b,
                                            input logic cin);
    add9 = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, cin};
  endfunction : add9

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    is_zero = (v == '0);
  endfunction : is_zero

  function automatic logic [PC_W-1:0] pc_next(input logic [PC_W-1:0] p);
    pc_next = p + 10'h001;
  endfunction : pc_next

  // Command decode
  balf_op_t cmd_op;
  logic cmd_imm;
  logic [RIDX_W-1:0] cmd_x;
  logic [RIDX_W-1:0] cmd_y;
  logic [DATA_W-1:0] cmd_k;
  logic [DATA_W-1:0] opa;
  logic [DATA_W-1:0] opb;
  logic [DATA_W:0] sum_plain;
  logic [DATA_W:0] sum_with_carry_in;
  logic [DATA_W-1:0] and_res;
  logic bus_done;
  logic exec;
  logic take_irq;
  logic reg_hit;
  logic [RIDX_W-1:0] reg_idx;

  assign cmd_op = balf_op_t'(avs_writedata[CMD_OP_LSB +: 3]);
  assign cmd_imm = avs_writedata[CMD_IMM_SEL];
  assign cmd_x = avs_writedata[CMD_X_LSB +: RIDX_W];
  assign cmd_y = avs_writedata[CMD_Y_LSB +: RIDX_W];
  assign cmd_k = avs_writedata[CMD_K_LSB +: DATA_W];
  assign opa = st_q.regs[cmd_x];
  assign opb = cmd_imm ? cmd_k : st_q.regs[cmd_y]; // [RULE5]
  assign sum_plain = add9(opa, opb, 1'b0); // [RULE4]
  assign sum_with_carry_in = add9(opa, opb, st_q.carry); // [RULE6]
  assign and_res = opa & opb; // [RULE9]

  // One wait cycle per access; data then stands from a flop
  assign avs_waitrequest = (avs_read | avs_write) & ~st_q.ack;
  assign avs_readdata = st_q.rdata;
  assign bus_done = (avs_read | avs_write) & st_q.ack;
  assign exec = bus_done & avs_write & (avs_address == OFS_CMD) &
                (avs_byteenable == 4'hf);
  assign reg_hit = (avs_address[7:6] == OFS_REGFILE[7:6]) &
                   (avs_address[1:0] == 2'b00);
  assign reg_idx = avs_address[5:2];
  // Interrupt waits for a free cycle so no instruction is split
  assign take_irq = irq & st_q.interrupt_enable_flag & ~exec; // [RULE16]

  always_comb begin
    st_d = st_q; // [RULE18]
    st_d.ack = (avs_read | avs_write) & ~st_q.ack;
    if ((avs_read | avs_write) & ~st_q.ack & avs_read) begin
      st_d.rdata = '0;
      if (reg_hit) begin
        st_d.rdata = {24'h000000, st_q.regs[reg_idx]};
      end else begin
        case (avs_address)
          OFS_STATUS: begin
            st_d.rdata[ST_ZERO] = st_q.zero;
            st_d.rdata[ST_CARRY] = st_q.carry;
            st_d.rdata[ST_INT_EN] = st_q.interrupt_enable_flag;
          end
          OFS_PC: st_d.rdata = {22'h0, st_q.pc};
          OFS_SAVED_PC: st_d.rdata = {22'h0, st_q.saved_pc};
          default: st_d.rdata = '0;
        endcase
      end
    end
    if (bus_done & avs_write & reg_hit & avs_byteenable[0]) begin
      st_d.regs[reg_idx] = avs_writedata[DATA_W-1:0];
    end
    // All right-hand values come from st_q; st_d commits at once
    if (exec) begin // [RULE11]
      case (cmd_op)
        BALF_OP_ADD: begin
          st_d.regs[cmd_x] = sum_plain[DATA_W-1:0]; // [RULE1]
          st_d.carry = sum_plain[DATA_W]; // [RULE2]
          st_d.zero = is_zero(sum_plain[DATA_W-1:0]); // [RULE3]
          st_d.pc = pc_next(st_q.pc); // [RULE17]
        end
        BALF_OP_ADDC: begin
          st_d.regs[cmd_x] = sum_with_carry_in[DATA_W-1:0]; // [RULE6]
          st_d.carry = sum_with_carry_in[DATA_W]; // [RULE7]
          st_d.zero = is_zero(sum_with_carry_in[DATA_W-1:0]); // [RULE8]
          st_d.pc = pc_next(st_q.pc); // [RULE17]
        end
        BALF_OP_AND: begin
          st_d.regs[cmd_x] = and_res; // [RULE9]
          st_d.carry = 1'b0; // [RULE10]
          st_d.zero = is_zero(and_res); // [RULE9]
          st_d.pc = pc_next(st_q.pc); // [RULE17]
        end
        BALF_OP_EINT: begin
          st_d.interrupt_enable_flag = 1'b1; // [RULE16]
          st_d.pc = pc_next(st_q.pc);
        end
        BALF_OP_DINT: begin
          st_d.interrupt_enable_flag = 1'b0;
          st_d.pc = pc_next(st_q.pc);
        end
        BALF_OP_RET_EN, BALF_OP_RET_DIS: begin
          st_d.pc = st_q.saved_pc;
          st_d.carry = st_q.saved_carry;
          st_d.zero = st_q.saved_zero;
          st_d.interrupt_enable_flag = (cmd_op == BALF_OP_RET_EN); // [RULE15]
        end
        default: st_d.pc = pc_next(st_q.pc);
      endcase
    end else if (take_irq) begin
      st_d.saved_pc = st_q.pc;
      st_d.saved_carry = st_q.carry;
      st_d.saved_zero = st_q.zero;
      st_d.pc = IRQ_VECTOR; // [RULE13]
      st_d.interrupt_enable_flag = 1'b0; // [RULE14]
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
      st_q.pc <= RESET_VECTOR; // [RULE12]
    end else begin
      st_q <= st_d;
    end
  end

  // Reference values for the checks below, built apart from the datapath
  logic [8:0] chk_sum;
  logic [8:0] chk_sumc;
  logic [7:0] chk_and;
  logic [7:0] chk_b;
  logic [7:0] chk_a;
  logic chk_c;
  assign chk_a = st_q.regs[cmd_x];
  assign chk_b = cmd_imm ? cmd_k : st_q.regs[cmd_y];
  assign chk_c = st_q.carry;
  assign chk_sum = 9'(chk_a) + 9'(chk_b);
  assign chk_sumc = 9'(chk_a) + 9'(chk_b) + 9'(chk_c);
  assign chk_and = chk_a & chk_b;

  property p_add_result;
    @(posedge sys_clk) disable iff (!rstn)
    exec && cmd_op == BALF_OP_ADD |=>
      st_q.regs[$past(cmd_x)] == $past(chk_sum[7:0]);
  endproperty
  a_add_result: assert property (p_add_result) // [RULE1]
    else $error("add result byte wrong");

  property p_add_carry;
    @(posedge sys_clk) disable iff (!rstn)
    exec && cmd_op == BALF_OP_ADD |=>
      st_q.carry == ($past(chk_sum) > 9'h0ff);
  endproperty
  a_add_carry: assert property (p_add_carry) // [RULE2]
    else $error("add carry wrong");

  property p_add_zero;
    @(posedge sys_clk) disable iff (!rstn)
    exec && cmd_op == BALF_OP_ADD |=>
      st_q.zero == ($past(chk_sum) == 9'h000 || $past(chk_sum) == 9'h100);
  endproperty
  a_add_zero: assert property (p_add_zero) // [RULE3]
    else $error("add zero wrong");

  property p_add_no_cin;
    @(posedge sys_clk) disable iff (!rstn)
    exec && cmd_op == BALF_OP_ADD && st_q.carry |=>
      st_q.regs[$past(cmd_x)] == $past(chk_sum[7:0]);
  endproperty
  a_add_no_cin: assert property (p_add_no_cin) // [RULE4]
    else $error("add used old carry");

  property p_imm_src;
    @(posedge sys_clk) disable iff (!rstn)
    exec && cmd_op == BALF_OP_AND && cmd_imm |=>
      st_q.regs[$past(cmd_x)] == ($past(chk_a) & $past(cmd_k));
  endproperty
  a_imm_src: assert property (p_imm_src) // [RULE5]
    else $error("immediate operand not used");

  property p_addc_result;
    @(posedge sys_clk) disable iff (!rstn)
    exec && cmd_op == BALF_OP_ADDC |=>
      st_q.regs[$past(cmd_x)] == $past(chk_sumc[7:0]);
  endproperty
  a_addc_result: assert property (p_addc_result) // [RULE6]
    else $error("add with carry result wrong");

  property p_addc_flags;
    @(posedge sys_clk) disable iff (!rstn)
    exec && cmd_op == BALF_OP_ADDC |=>
      st_q.carry == $past(chk_sumc[8]) &&
      st_q.zero == ($past(chk_sumc[7:0]) == 8'h00);
  endproperty
  a_addc_flags: assert property (p_addc_flags) // [RULE7] [RULE8]
    else $error("add with carry flags wrong");

  property p_and_flags;
    @(posedge sys_clk) disable iff (!rstn)
    exec && cmd_op == BALF_OP_AND |=>
      !st_q.carry && st_q.zero == ($past(chk_and) == 8'h00);
  endproperty
  a_and_flags: assert property (p_and_flags) // [RULE9] [RULE10]
    else $error("and flags wrong");

  property p_pc_step;
    @(posedge sys_clk) disable iff (!rstn)
    exec && (cmd_op == BALF_OP_ADD || cmd_op == BALF_OP_ADDC ||
             cmd_op == BALF_OP_AND) |=> st_q.pc == $past(st_q.pc) + 10'h001;
  endproperty
  a_pc_step: assert property (p_pc_step) // [RULE17] [RULE11]
    else $error("pc did not step by one");

  property p_irq_entry;
    @(posedge sys_clk) disable iff (!rstn)
    irq && st_q.interrupt_enable_flag && !exec |=>
      st_q.pc == 10'h3ff && !st_q.interrupt_enable_flag &&
      st_q.saved_pc == $past(st_q.pc);
  endproperty
  a_irq_entry: assert property (p_irq_entry) // [RULE13] [RULE14]
    else $error("interrupt entry wrong");

  property p_irq_gated;
    @(posedge sys_clk) disable iff (!rstn)
    !st_q.interrupt_enable_flag && !exec |=> st_q.pc == $past(st_q.pc);
  endproperty
  a_irq_gated: assert property (p_irq_gated) // [RULE16]
    else $error("pc moved while interrupts disabled");

  property p_return;
    @(posedge sys_clk) disable iff (!rstn)
    exec && (cmd_op == BALF_OP_RET_EN || cmd_op == BALF_OP_RET_DIS) |=>
      st_q.interrupt_enable_flag == ($past(cmd_op) == BALF_OP_RET_EN) &&
      st_q.pc == $past(st_q.saved_pc);
  endproperty
  a_return: assert property (p_return) // [RULE15]
    else $error("return from interrupt wrong");

  property p_flags_hold;
    @(posedge sys_clk) disable iff (!rstn)
    !exec && !take_irq |=> $stable(st_q.carry) && $stable(st_q.zero);
  endproperty
  a_flags_hold: assert property (p_flags_hold) // [RULE18]
    else $error("flags changed without an operation");

  property p_reset_pc;
    @(posedge sys_clk) $rose(rstn) |-> st_q.pc == 10'h000;
  endproperty
  a_reset_pc: assert property (p_reset_pc) // [RULE12]
    else $error("pc not zero after reset");

  property p_bus_one_wait;
    @(posedge sys_clk) disable iff (!rstn)
    (avs_read || avs_write) && !st_q.ack |=> !avs_waitrequest;
  endproperty
  a_bus_one_wait: assert property (p_bus_one_wait)
    else $error("bus answer late");

  property p_and_result;
    @(posedge sys_clk) disable iff (!rstn)
    exec && cmd_op == BALF_OP_AND |=>
      st_q.regs[$past(cmd_x)] == $past(chk_and);
  endproperty
  a_and_result: assert property (p_and_result) // [RULE9]
    else $error("and result byte wrong");

  property p_eint_sets;
    @(posedge sys_clk) disable iff (!rstn)
    exec && cmd_op == BALF_OP_EINT |=> st_q.interrupt_enable_flag;
  endproperty
  a_eint_sets: assert property (p_eint_sets) // [RULE16]
    else $error("enable instruction did not set the flag");

  // Refused commands are still answered but must leave state alone
  property p_cmd_partial;
    @(posedge sys_clk) disable iff (!rstn)
    bus_done && avs_write && avs_address == OFS_CMD &&
      avs_byteenable != 4'hf && !take_irq |=>
      $stable(st_q.pc) && $stable(st_q.carry) && $stable(st_q.zero);
  endproperty
  a_cmd_partial: assert property (p_cmd_partial)
    else $error("partial command word changed state");

  // Return restores these, so entry must capture the live flags
  property p_irq_saves_flags;
    @(posedge sys_clk) disable iff (!rstn)
    take_irq |=> st_q.saved_carry == $past(st_q.carry) &&
      st_q.saved_zero == $past(st_q.zero);
  endproperty
  a_irq_saves_flags: assert property (p_irq_saves_flags)
    else $error("flags not saved at interrupt entry");
endmodule : balf_core

/* File: bench/test_byte_alu_add_logic_flags.sv */
`timescale 1ns/1ps
module test_byte_alu_add_logic_flags;
  import balf_pkg::*;
  typedef struct packed {
    balf_op_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic imm;
    logic cin;
    logic [7:0] res;
    logic z;
    logic c;
  } balf_row_t;
  logic sys_clk;
  logic rstn;
  logic irq;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] rd;
  logic [PC_W-1:0] exp_pc;
  logic [PC_W-1:0] saved;
  balf_row_t r;
  int err_count;
  int check_count;
  // Source register r0 holds ~b on immediate rows to expose a wrong select
  balf_row_t rows [10] = '{
    '{BALF_OP_ADD, 8'hff, 8'h01, 1'b0, 1'b1, 8'h00, 1'b1, 1'b1},
    '{BALF_OP_ADD, 8'h80, 8'h7f, 1'b1, 1'b1, 8'hff, 1'b0, 1'b0},
    '{BALF_OP_ADD, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0},
    '{BALF_OP_ADDC, 8'hff, 8'h00, 1'b0, 1'b1, 8'h00, 1'b1, 1'b1},
    '{BALF_OP_ADDC, 8'h7f, 8'h80, 1'b1, 1'b0, 8'hff, 1'b0, 1'b0},
    '{BALF_OP_ADDC, 8'hfe, 8'h01, 1'b1, 1'b1, 8'h00, 1'b1, 1'b1},
    '{BALF_OP_ADDC, 8'h10, 8'h20, 1'b0, 1'b1, 8'h31, 1'b0, 1'b0},
    '{BALF_OP_AND, 8'hf0, 8'h0f, 1'b0, 1'b1, 8'h00, 1'b1, 1'b0},
    '{BALF_OP_AND, 8'hff, 8'ha5, 1'b1, 1'b1, 8'ha5, 1'b0, 1'b0},
    '{BALF_OP_ADDC, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0}
  };

  balf_core u_dut (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .irq(irq),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  always #50 sys_clk = ~sys_clk;

  task automatic finish_test;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                          input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_word

  // Entered just after a rising edge; waitrequest and read data are
  // taken at each rising edge, before the design updates them
  task automatic bus(input logic rnw, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= rnw;
    avs_write <= !rnw;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(posedge sys_clk);
    end
    if (n == 20) begin
      err_count++;
      $display("wrong value at %0t: bus hang", $time);
      finish_test();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d, 4'hf);
  endtask : wr

  task automatic rdw(input logic [7:0] a);
    bus(1'b1, a, 32'h0, 4'h0);
  endtask : rdw

  function automatic logic [7:0] ra(input logic [3:0] i);
    return OFS_REGFILE + {2'b00, i, 2'b00};
  endfunction : ra

  task automatic cmd(input balf_op_t op, input logic imm, input logic [3:0] x,
                     input logic [3:0] y, input logic [7:0] k);
    wr(OFS_CMD, {8'h00, k, 4'h0, y, x, imm, op});
    exp_pc = exp_pc + 10'h001;
  endtask : cmd

  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    irq = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    err_count = 0;
    check_count = 0;
    exp_pc = RESET_VECTOR;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rdw(OFS_PC);
    chk_word(rd, 32'h0, "pc after reset");
    rdw(OFS_STATUS);
    chk_word(rd, 32'h0, "flags after reset");
    wr(8'h20, 32'h5a);
    rdw(8'h20);
    chk_word(rd, 32'h0, "unmapped");
    foreach (rows[i]) begin
      r = rows[i];
      wr(ra(4'd14), 32'hff);
      wr(ra(4'd13), {31'h0, rows[i].cin});
      cmd(BALF_OP_ADD, 1'b0, 4'd14, 4'd13, 8'h00);
      wr(ra(4'd0), {24'h0, rows[i].imm ? ~rows[i].b : rows[i].b});
      wr(ra(4'(i + 1)), {24'h0, rows[i].a});
      cmd(rows[i].op, rows[i].imm, 4'(i + 1), 4'd0, rows[i].b);
      rdw(ra(4'(i + 1)));
      chk_word(rd, {24'h0, r.res}, "res");
      rdw(OFS_STATUS);
      chk_word(rd, {30'h0, r.c, r.z}, "flags");
      chk_word(32'(rd[ST_ZERO]), 32'(r.z), "zero");
      chk_word(32'(rd[ST_CARRY]), 32'(r.c), "carry");
      rdw(OFS_PC);
      chk_word(rd, {22'h0, exp_pc}, "pc");
    end
    wr(ra(4'd5), 32'h81);
    cmd(BALF_OP_ADD, 1'b0, 4'd5, 4'd5, 8'h00);
    rdw(ra(4'd5));
    chk_word(rd, 32'h02, "same reg");
    cmd(BALF_OP_NOP, 1'b0, 4'd0, 4'd0, 8'h00);
    bus(1'b0, OFS_CMD, 32'h0, 4'h3);
    rdw(OFS_STATUS);
    chk_word(rd, 32'h2, "flags kept");
    rdw(OFS_PC);
    chk_word(rd, {22'h0, exp_pc}, "partial cmd");
    cmd(BALF_OP_EINT, 1'b0, 4'd0, 4'd0, 8'h00);
    rdw(OFS_STATUS);
    chk_word(rd, 32'h6, "int enable set");
    cmd(BALF_OP_DINT, 1'b0, 4'd0, 4'd0, 8'h00);
    irq <= 1'b1;
    cmd(BALF_OP_NOP, 1'b0, 4'd0, 4'd0, 8'h00);
    rdw(OFS_PC);
    chk_word(rd, {22'h0, exp_pc}, "irq masked");
    cmd(BALF_OP_EINT, 1'b0, 4'd0, 4'd0, 8'h00);
    saved = exp_pc;
    rdw(OFS_PC);
    chk_word(rd, {22'h0, IRQ_VECTOR}, "vector");
    rdw(OFS_SAVED_PC);
    chk_word(rd, {22'h0, saved}, "saved pc");
    rdw(OFS_STATUS);
    chk_word(rd, 32'h2, "int enable cleared");
    cmd(BALF_OP_RET_DIS, 1'b0, 4'd0, 4'd0, 8'h00);
    rdw(OFS_PC);
    chk_word(rd, {22'h0, saved}, "ret keep off");
    rdw(OFS_STATUS);
    chk_word(rd, 32'h2, "int enable still off");
    cmd(BALF_OP_RET_EN, 1'b0, 4'd0, 4'd0, 8'h00);
    rdw(OFS_PC);
    chk_word(rd, {22'h0, IRQ_VECTOR}, "ret re-enable");
    irq <= 1'b0;
    // Second reset mid-run; all state must return to its reset values
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rdw(OFS_PC);
    chk_word(rd, 32'h0, "pc after second reset");
    rdw(OFS_STATUS);
    chk_word(rd, 32'h0, "flags after second reset");
    rdw(ra(4'd5));
    chk_word(rd, 32'h0, "reg after second reset");
    finish_test();
  end
endmodule : test_byte_alu_add_logic_flags
